// >>> design/flash_core.sv
/*
  Storage core of a serial flash: sector array, SRAM, program buffer,
  programming timer and write protection, reached over APB.
  Assumes command framing happens elsewhere; the protect pin arrives
  asynchronously and is synchronised here.
*/
// The placing of the registers and register access over APB were chosen for this implementation.
module flash_core
  import flash_core_pkg::*;
#(
  parameter int NUM_SECTORS = SECTORS_SMALL,
  parameter int TWP_CYC = TWP_CYCLES
) (
  // Clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_CE,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Pins
  input wire logic I_WP_N,
  output logic O_RB,
  output logic O_RB_OE
);

  localparam int SECT_W = $clog2(NUM_SECTORS);
  localparam int CNT_W = $clog2(TWP_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TWP_CYC - 1);

  typedef enum {ST_IDLE, ST_PROG} prog_e;

  // Storage, all flip-flops
  logic [7:0] array_mem [NUM_SECTORS][SECTOR_BYTES];
  logic [7:0] sram [SECTOR_BYTES];
  logic [7:0] pbuf [SECTOR_BYTES];

  // Control state
  prog_e prog_r;
  logic [CNT_W-1:0] cnt_r;
  logic [SECT_W-1:0] prog_sec_r;
  logic [SECT_W-1:0] sec_r;
  logic [8:0] byte_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic [31:0] prdata_r;
  cfg_s cfg_r;
  logic wr_en_r;
  logic match_r;
  logic refused_r;
  logic wp_s1_r, wp_s2_r, wp_s3_r;
  logic wp_n_r;

  // Decoded strobes
  logic wr_acc;
  logic cmd_go;
  logic [3:0] cmd;
  logic busy;
  logic in_range;
  logic protect;
  logic prog_start;
  logic prog_done;
  logic array_cmd;
  logic byte_step;
  logic mapped;
  logic [8:0] byte_nxt;
  logic [SECT_W:0] blk_span;
  stat_s stat;
  pin_s pin;

  // Bus decode; the slave answers with no wait state while enabled
  assign mapped = (I_PADDR == OFS_CMD) || (I_PADDR == OFS_ADDR) || (I_PADDR == OFS_DATA)
               || (I_PADDR == OFS_CFG) || (I_PADDR == OFS_STAT);
  assign O_PREADY = I_CE;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
  assign wr_acc = I_CE & I_PSEL & I_PENABLE & I_PWRITE & mapped;
  assign cmd_go = wr_acc && (I_PADDR == OFS_CMD);
  assign cmd = I_PWDATA[3:0];
  assign O_PRDATA = prdata_r;

  // Busy while the program buffer drains into the array
  assign busy = (prog_r == ST_PROG);
  assign prog_done = busy && (cnt_r == CNT_LAST);

  // Range protection in blocks of 32 sectors, from bottom or top
  assign blk_span = (SECT_W + 1)'(cfg_r.wp_range) * (SECT_W + 1)'(BLOCK_SECTORS);
  always_comb begin
    in_range = 1'b0;
    if (cfg_r.wp_range == 4'hf) begin
      in_range = 1'b1;
    end else if (cfg_r.wp_range != 4'h0) begin
      if (cfg_r.wp_dir) begin
        in_range = ({1'b0, sec_r} >= ((SECT_W + 1)'(NUM_SECTORS) - blk_span));
      end else begin
        in_range = ({1'b0, sec_r} < blk_span);
      end
    end
  end

  // Pin low overrides the range; software disable covers everything
  assign protect = ~wp_n_r | in_range | ~wr_en_r;

  // Array operations only while idle
  assign array_cmd = cmd_go && ((cmd == CMD_RD_SECTOR) || (cmd == CMD_WR_SECT_END)
                  || (cmd == CMD_SRAM_TO_SECT) || (cmd == CMD_SECT_TO_SRAM)
                  || (cmd == CMD_COMPARE) || (cmd == CMD_SRAM_TO_PBUF)
                  || (cmd == CMD_PBUF_TO_SRAM));
  assign prog_start = cmd_go && !busy && !protect
                   && ((cmd == CMD_WR_SECT_END) || (cmd == CMD_SRAM_TO_SECT));

  // Byte commands that advance the pointer; busy-gated ones only when idle
  assign byte_step = cmd_go && ((cmd == CMD_RD_SRAM) || (cmd == CMD_WR_SRAM)
                  || (cmd == CMD_WR_SECT_BYTE) || (cmd == CMD_RD_PBUF)
                  || ((cmd == CMD_RD_SECTOR) && !busy));
  assign byte_nxt = (byte_r == LAST_BYTE) ? 9'h000 : byte_r + 9'h001;

  // Protect pin: three stages, accepted once stages two and three agree
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      wp_s1_r <= 1'b1;
      wp_s2_r <= 1'b1;
      wp_s3_r <= 1'b1;
      wp_n_r <= 1'b1;
    end else if (I_CE) begin
      wp_s1_r <= I_WP_N;
      wp_s2_r <= wp_s1_r;
      wp_s3_r <= wp_s2_r;
      if (wp_s2_r == wp_s3_r) begin
        wp_n_r <= wp_s3_r;
      end
    end
  end

  // Programming timer: erase at start, buffer written at the end
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      prog_r <= ST_IDLE;
      cnt_r <= '0;
      prog_sec_r <= '0;
    end else if (I_CE) begin
      unique case (prog_r)
        ST_IDLE: begin
          if (prog_start) begin
            prog_r <= ST_PROG;
            cnt_r <= '0;
            prog_sec_r <= sec_r;
          end
        end
        ST_PROG: begin
          if (prog_done) begin
            prog_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r + CNT_W'(1);
          end
        end
      endcase
    end
  end

  // Array contents; nonvolatile, so no reset
  always_ff @(posedge I_CLK) begin
    if (I_CE) begin
      if (prog_start) begin
        array_mem[sec_r] <= '{default: 8'hff};
      end else if (prog_done) begin
        array_mem[prog_sec_r] <= pbuf;
      end
    end
  end

  // SRAM contents; host bytes land here even during programming
  always_ff @(posedge I_CLK) begin
    if (I_CE && cmd_go) begin
      if ((cmd == CMD_WR_SRAM) || (cmd == CMD_WR_SECT_BYTE)) begin
        sram[byte_r] <= wdata_r;
      end else if ((cmd == CMD_SECT_TO_SRAM) && !busy) begin
        sram <= array_mem[sec_r];
      end else if ((cmd == CMD_PBUF_TO_SRAM) && !busy) begin
        sram <= pbuf;
      end
    end
  end

  // Program buffer; only loaded from the SRAM, never while draining
  always_ff @(posedge I_CLK) begin
    if (I_CE) begin
      if (prog_start) begin
        pbuf <= sram;
      end else if (cmd_go && (cmd == CMD_SRAM_TO_PBUF) && !busy) begin
        pbuf <= sram;
      end
    end
  end

  // Address pointer and read data; sector reads start at any byte
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      sec_r <= '0;
      byte_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
    end else if (I_CE) begin
      if (wr_acc && (I_PADDR == OFS_ADDR)) begin
        sec_r <= I_PWDATA[ADDR_SECT_LSB +: SECT_W];
        if (I_PWDATA[ADDR_BYTE_LSB +: 9] > LAST_BYTE) begin
          byte_r <= LAST_BYTE; // Clamp: no byte past 107H exists
        end else begin
          byte_r <= I_PWDATA[ADDR_BYTE_LSB +: 9];
        end
      end else if (byte_step) begin
        byte_r <= byte_nxt;
      end
      if (wr_acc && (I_PADDR == OFS_DATA)) begin
        wdata_r <= I_PWDATA[7:0];
      end
      if (cmd_go && (cmd == CMD_RD_SECTOR) && !busy) begin
        rdata_r <= array_mem[sec_r][byte_r];
      end else if (cmd_go && (cmd == CMD_RD_SRAM)) begin
        rdata_r <= sram[byte_r];
      end else if (cmd_go && (cmd == CMD_RD_PBUF)) begin
        rdata_r <= pbuf[byte_r];
      end
    end
  end

  // Configuration and software protection
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      cfg_r <= cfg_s'(CFG_RESET);
      wr_en_r <= 1'b0;
    end else if (I_CE) begin
      if (wr_acc && (I_PADDR == OFS_CFG)) begin
        cfg_r <= cfg_s'(I_PWDATA[8:0]);
      end
      if (cmd_go && (cmd == CMD_WR_ENABLE)) begin
        wr_en_r <= 1'b1;
      end else if (cmd_go && (cmd == CMD_WR_DISABLE)) begin
        wr_en_r <= 1'b0;
      end
    end
  end

  // Compare result and refusal flag; a new refusal beats a clear
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      match_r <= 1'b0;
      refused_r <= 1'b0;
    end else if (I_CE) begin
      if (cmd_go && (cmd == CMD_COMPARE) && !busy) begin
        match_r <= (sram == array_mem[sec_r]);
      end
      if ((array_cmd && busy) || (cmd_go && !busy && protect
          && ((cmd == CMD_WR_SECT_END) || (cmd == CMD_SRAM_TO_SECT)))) begin
        refused_r <= 1'b1;
      end else if (wr_acc && (I_PADDR == OFS_STAT) && I_PWDATA[STAT_REFUSED_BIT]) begin
        refused_r <= 1'b0;
      end
    end
  end

  // Status word as software sees it
  assign stat = '{refused: refused_r, wp_pin: wp_n_r, wr_enabled: wr_en_r,
                  match: match_r, ready: ~busy};

  // Read data captured in the setup cycle, presented in the access cycle
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      prdata_r <= '0;
    end else if (I_CE && I_PSEL && !I_PENABLE && !I_PWRITE) begin
      unique case (I_PADDR)
        OFS_ADDR: prdata_r <= 32'(sec_r) << ADDR_SECT_LSB | 32'(byte_r);
        OFS_DATA: prdata_r <= {24'h000000, rdata_r};
        OFS_CFG: prdata_r <= {23'h000000, cfg_r};
        OFS_STAT: prdata_r <= {27'h0000000, stat};
        default: prdata_r <= '0;
      endcase
    end
  end

  // Ready/busy pin: push-pull or open drain, else released
  always_comb begin
    pin = '{out: 1'b0, oe: 1'b0};
    if (cfg_r.pin_fn == PIN_RB) begin
      pin = '{out: ~busy, oe: 1'b1};
    end else if (cfg_r.pin_fn == PIN_RB_OD) begin
      pin = '{out: 1'b0, oe: busy};
    end
  end
  assign O_RB = pin.out;
  assign O_RB_OE = pin.oe;

endmodule : flash_core

// >>> design/flash_core_pkg.sv
/*
  Shared constants and carriers for the sector flash storage core:
  array geometry, register map, command codes, configuration fields and
  programming time. Assumes a 100 MHz core clock and an APB register bus.
*/
package flash_core_pkg;

  // Array geometry
  localparam int SECTORS_SMALL = 512;
  localparam int SECTORS_LARGE = 2048;
  localparam int SECTOR_BYTES = 264;
  localparam logic [8:0] LAST_BYTE = 9'h107;
  localparam int BLOCK_SECTORS = 32;

  // Programming time, 5 ms at 10 ns per cycle
  localparam int CLK_PERIOD_NS = 10;
  localparam int TWP_NS = 5000000;
  localparam int TWP_CYCLES = TWP_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_CFG = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // Address register field positions
  localparam int ADDR_BYTE_LSB = 0;
  localparam int ADDR_SECT_LSB = 16;

  // Command codes written to the command register
  localparam logic [3:0] CMD_RD_SECTOR = 4'h1;
  localparam logic [3:0] CMD_WR_SECT_BYTE = 4'h2;
  localparam logic [3:0] CMD_WR_SECT_END = 4'h3;
  localparam logic [3:0] CMD_RD_SRAM = 4'h4;
  localparam logic [3:0] CMD_WR_SRAM = 4'h5;
  localparam logic [3:0] CMD_SECT_TO_SRAM = 4'h6;
  localparam logic [3:0] CMD_SRAM_TO_SECT = 4'h7;
  localparam logic [3:0] CMD_COMPARE = 4'h8;
  localparam logic [3:0] CMD_SRAM_TO_PBUF = 4'h9;
  localparam logic [3:0] CMD_PBUF_TO_SRAM = 4'ha;
  localparam logic [3:0] CMD_RD_PBUF = 4'hb;
  localparam logic [3:0] CMD_WR_ENABLE = 4'hc;
  localparam logic [3:0] CMD_WR_DISABLE = 4'hd;

  // Ready/busy pin function codes
  localparam logic [1:0] PIN_HOLD = 2'h0;
  localparam logic [1:0] PIN_NC = 2'h1;
  localparam logic [1:0] PIN_RB_OD = 2'h2;
  localparam logic [1:0] PIN_RB = 2'h3;

  // Configuration fields, bit 8 down to bit 0
  typedef struct packed {
    logic alt_osc;
    logic [3:0] wp_range;
    logic wp_dir;
    logic rd_edge;
    logic [1:0] pin_fn;
  } cfg_s;

  localparam logic [8:0] CFG_RESET = 9'h009;

  // Status fields, bit 4 down to bit 0
  typedef struct packed {
    logic refused;
    logic wp_pin;
    logic wr_enabled;
    logic match;
    logic ready;
  } stat_s;

  localparam int STAT_REFUSED_BIT = 4;

  // Ready/busy pin carrier
  typedef struct packed {
    logic out;
    logic oe;
  } pin_s;

endpackage : flash_core_pkg

// >>> testbench/flash_core_sva.sv
/*
  Port checker for the flash core: APB answers and the ready/busy pin.
  Assumes one clock domain and a synchronous active-low reset.
*/
module flash_core_sva
  import flash_core_pkg::*;
#(
  parameter int TWP_CYC = TWP_CYCLES
) (
  // Clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_CE,
  // APB
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // Pin
  input wire logic O_RB,
  input wire logic O_RB_OE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  logic [31:0] low_cnt;
  logic acc;
  logic prog;
  // Access phase and program command decode
  assign acc = I_PSEL && I_PENABLE && I_CE;
  assign prog = I_PWRITE && I_PADDR == OFS_CMD
    && I_PWDATA[3:0] inside {CMD_WR_SECT_END, CMD_SRAM_TO_SECT};
  // Length of the current busy stretch; a counter, as the count is long
  always_ff @(posedge I_CLK) begin
    if (!I_NRST || !(O_RB_OE && !O_RB)) low_cnt <= 32'h0;
    else if (I_CE) low_cnt <= low_cnt + 32'h1;
  end
  rb_start_a: assert property ($fell(O_RB) && O_RB_OE |-> $past(acc && prog))
    else $error("busy without a program command");
  rb_bound_a: assert property (low_cnt <= TWP_CYC)
    else $error("busy longer than programming time");
  rb_full_a: assert property ($rose(O_RB) && $past(O_RB_OE) |-> low_cnt >= TWP_CYC - 1)
    else $error("busy ended early");
  rb_hold_a: assert property ($fell(O_RB) && O_RB_OE |-> (!O_RB && O_RB_OE) [*8])
    else $error("busy cut short");
  rb_reset_a: assert property ($rose(I_NRST) |-> !O_RB_OE && O_PRDATA == 32'h0)
    else $error("pin or data wrong after reset");
  stat_ready_a: assert property (acc && !I_PWRITE && I_PADDR == OFS_STAT
    && O_RB_OE && $past(O_RB_OE) |-> O_PRDATA[0] == $past(O_RB))
    else $error("status ready differs from pin");
  busy_serve_a: assert property (acc && !O_RB && O_RB_OE && I_PADDR == OFS_DATA
    |-> O_PREADY && !O_PSLVERR)
    else $error("data access refused while busy");
  addr_clamp_a: assert property (acc && !I_PWRITE && I_PADDR == OFS_ADDR
    |-> O_PRDATA[8:0] <= LAST_BYTE)
    else $error("byte index beyond sector");
  cover property ($fell(O_RB) && O_RB_OE);
  cover property ($rose(O_RB) && $past(O_RB_OE));
  cover property (acc && O_PSLVERR);
endmodule : flash_core_sva

bind flash_core flash_core_sva #(.TWP_CYC(TWP_CYC)) SVA (.I_CLK(I_CLK), .I_NRST(I_NRST),
  .I_CE(I_CE), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
  .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_RB(O_RB), .O_RB_OE(O_RB_OE));

// >>> testbench/pin_host.sv
/*
  Host-side pin model: drives the protect pin, resolves the ready wire.
  Assumes a pull-up on the ready/busy line.
*/
module pin_host (
  // Clock and request
  input wire logic i_clk,
  input wire logic i_wp_req,
  // Ready/busy pin
  input wire logic i_rb,
  input wire logic i_rb_oe,
  // Wires
  output logic o_wp_n,
  output logic o_rb_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_wp_n = 1'b1;
  // Protect pin low while protection is asked for
  always @(posedge i_clk) o_wp_n <= ~i_wp_req;
  // Pull-up wins when undriven, as open drain needs
  assign o_rb_wire = i_rb_oe ? i_rb : 1'b1;
endmodule : pin_host

// >>> testbench/tb.sv
/*
  Bench for the flash core: APB tasks run command sequences, compares
  check read data. Assumes zero-wait answers and a 40-cycle program.
*/
module tb
  import flash_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TWP = 40;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic wp_req = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0, prdata, d;
  logic pready, pslverr, perr, wp_n, rb, rb_oe, rb_wire;
  int err_total = 0, cmp_count = 0;
  // Clock, short program time keeps the run brief
  always #5 clk = ~clk;
  flash_core #(.TWP_CYC(TWP)) DUT (.I_CLK(clk), .I_NRST(nrst), .I_CE(ce), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr), .I_PWDATA(pwd), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_WP_N(wp_n), .O_RB(rb), .O_RB_OE(rb_oe));
  pin_host HOST (.i_clk(clk), .i_wp_req(wp_req), .i_rb(rb), .i_rb_oe(rb_oe),
    .o_wp_n(wp_n), .o_rb_wire(rb_wire));
  // One APB transfer; idle edge after it avoids double drive
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= v;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask : wr
  task automatic cmd(input logic [3:0] c);
    xfer(1'b1, OFS_CMD, {28'h0, c});
  endtask : cmd
  task automatic seta(input logic [10:0] s, input logic [8:0] b);
    wr(OFS_ADDR, {5'h0, s, 7'h0, b});
  endtask : seta
  task automatic byterd(input logic [3:0] c, input logic [7:0] e);
    cmd(c);
    xfer(1'b0, OFS_DATA, 32'h0);
    chk(d, {24'h0, e});
  endtask : byterd
  // Refused and ready flags, then clear refused
  task automatic stchk(input logic [1:0] e);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk({30'h0, d[4], d[0]}, {30'h0, e});
    wr(OFS_STAT, 32'h10);
  endtask : stchk
  task automatic match(input logic e);
    cmd(CMD_COMPARE);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk({31'h0, d[1]}, {31'h0, e});
  endtask : match
  task automatic fill(input logic [3:0] c, input logic [10:0] s, input logic [7:0] x);
    seta(s, 9'h0);
    for (int i = 0; i < SECTOR_BYTES; i++) begin
      wr(OFS_DATA, {24'h0, 8'(i) ^ x});
      cmd(c);
    end
  endtask : fill
  task automatic waitrdy;
    for (int n = 0; n < 100 && rb_wire !== 1'b1; n++) @(posedge clk);
    chk({31'h0, rb_wire}, 32'h1);
  endtask : waitrdy
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // Watchdog, about sixteen times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    results();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    xfer(1'b0, 8'h20, 32'h0);
    chk({31'h0, perr}, 32'h1);
    xfer(1'b0, OFS_CFG, 32'h0);
    chk(d, {23'h0, CFG_RESET});
    stchk(2'b01);
    wr(OFS_CFG, 32'h003);
    fill(CMD_WR_SRAM, 11'd5, 8'h5a);
    cmd(CMD_SRAM_TO_SECT);
    stchk(2'b11);
    cmd(CMD_WR_ENABLE);
    cmd(CMD_SRAM_TO_SECT);
    chk({31'h0, rb_wire}, 32'h0);
    seta(11'd5, 9'h3);
    cmd(CMD_RD_SECTOR);
    stchk(2'b10);
    seta(11'd0, 9'h0);
    wr(OFS_DATA, 32'hee);
    cmd(CMD_WR_SRAM);
    waitrdy();
    seta(11'd5, 9'h3);
    byterd(CMD_RD_SECTOR, 8'h03 ^ 8'h5a);
    byterd(CMD_RD_SECTOR, 8'h04 ^ 8'h5a);
    seta(11'd0, 9'h0);
    byterd(CMD_RD_SRAM, 8'hee);
    seta(11'd5, 9'h0);
    match(1'b0);
    wr(OFS_DATA, 32'h5a);
    cmd(CMD_WR_SRAM);
    match(1'b1);
    xfer(1'b0, OFS_ADDR, 32'h0);
    chk(d, 32'h00050001);
    fill(CMD_WR_SECT_BYTE, 11'd7, 8'ha5);
    cmd(CMD_WR_SECT_END);
    chk({31'h0, rb_wire}, 32'h0);
    waitrdy();
    seta(11'd7, 9'h9);
    byterd(CMD_RD_SECTOR, 8'h09 ^ 8'ha5);
    seta(11'd5, 9'h3);
    cmd(CMD_SECT_TO_SRAM);
    byterd(CMD_RD_SRAM, 8'h03 ^ 8'h5a);
    seta(11'd0, 9'h3);
    byterd(CMD_RD_PBUF, 8'h03 ^ 8'ha5);
    cmd(CMD_PBUF_TO_SRAM);
    seta(11'd0, 9'h3);
    byterd(CMD_RD_SRAM, 8'h03 ^ 8'ha5);
    seta(11'd0, 9'h3);
    wr(OFS_DATA, 32'h11);
    cmd(CMD_WR_SRAM);
    cmd(CMD_SRAM_TO_PBUF);
    seta(11'd0, 9'h3);
    byterd(CMD_RD_PBUF, 8'h11);
    wr(OFS_CFG, 32'h013);
    seta(11'd5, 9'h3);
    cmd(CMD_SRAM_TO_SECT);
    stchk(2'b11);
    byterd(CMD_RD_SECTOR, 8'h03 ^ 8'h5a);
    wr(OFS_CFG, 32'h01a);
    cmd(CMD_SRAM_TO_SECT);
    chk({31'h0, rb_wire}, 32'h0);
    ce <= 1'b0;
    repeat (50) @(posedge clk);
    chk({31'h0, rb_wire}, 32'h0);
    ce <= 1'b1;
    waitrdy();
    wr(OFS_CFG, 32'h003);
    wp_req <= 1'b1;
    repeat (6) @(posedge clk);
    cmd(CMD_SRAM_TO_SECT);
    stchk(2'b11);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk({30'h0, d[3], d[2]}, 32'h1);
    wp_req <= 1'b0;
    repeat (6) @(posedge clk);
    cmd(CMD_WR_DISABLE);
    cmd(CMD_SRAM_TO_SECT);
    stchk(2'b11);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk({30'h0, d[3], d[2]}, 32'h2);
    results();
  end
endmodule : tb
